// File: inc/sli_pkg.sv
// Constants and types shared by the status indicator logic
package sli_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int FAST_HZ = 10;
	localparam int SLOW_HZ = 2;
	localparam int FAST_HALF_CYC = CLK_HZ / (2 * FAST_HZ);
	localparam int SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_HZ);
	localparam int MIN_START_MS = 3000;
	localparam int MIN_START_CYC = (CLK_HZ / 1000) * MIN_START_MS;
	localparam int HOLD_W = 29;

	// ------------------------------------------------------------
	// Register map and fields
	// ------------------------------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_INT_STAT = 4'h8;
	localparam logic [3:0] REG_INT_MASK = 4'hc;
	localparam int CTRL_EN_BIT = 0;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam int INT_FAULT = 0;
	localparam int INT_FDONE = 1;
	localparam int INT_MEMRST = 2;
	localparam logic [2:0] INT_MASK_RST = 3'h0;

	// ------------------------------------------------------------
	// Display modes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		M_OFF, M_FW_LOAD, M_INIT1, M_INIT2, M_INIT3, M_INIT4,
		M_STOP, M_STARTUP, M_RUN, M_CFG_LOAD, M_OVR_REQ,
		M_OVR_EXEC, M_FACT_EXEC, M_FACT_DONE
	} sli_mode_t;
endpackage

// File: hdl/sli_blink.sv
// Free-running blink phase generator from the system clock
module sli_blink
	import sli_pkg::*;
#(
	parameter int HALF = FAST_HALF_CYC
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Blink phase
	output logic phase
);
	typedef struct packed {
		logic [31:0] cnt;
		logic ph;
	} sli_blink_t;

	sli_blink_t r;
	sli_blink_t n;

	// Prescaler toggles the phase every HALF cycles
	always_comb
	begin
		n = r;
		if (r.cnt == 32'(HALF - 1))
		begin
			n.cnt = 32'h0;
			n.ph = ~r.ph;
		end
		else
			n.cnt = r.cnt + 32'h1;
	end

	// State register
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			r <= '0;
		else
			r <= n;
	end

	assign phase = r.ph;
endmodule

// File: hdl/sli_top.sv
// Front-panel status indicator controller
module sli_top
	import sli_pkg::*;
#(
	parameter int FAST_HALF = FAST_HALF_CYC,
	parameter int SLOW_HALF = SLOW_HALF_CYC,
	parameter int MIN_START = MIN_START_CYC
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Operating state controller
	input wire logic fw_loading,
	input wire logic [2:0] init_phase,
	input wire logic startup_busy,
	input wire logic run_state,
	input wire logic sys_fault,
	input wire logic vars_forced,
	input wire logic card_access,
	input wire logic cfg_loading,
	input wire logic ovr_req,
	input wire logic ovr_exec,
	input wire logic fact_exec,
	input wire logic fact_done,
	input wire logic project_on_card,
	// Mode switch pin
	input wire logic memory_reset_position,
	// Requests to the controller
	output logic ovr_reset_req,
	output logic card_load_req,
	// Indicators
	output logic run_indicator,
	output logic stop_indicator,
	output logic fault_indicator,
	output logic force_indicator,
	output logic card_indicator,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic irq
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		sli_mode_t mode;
		logic booted;
		logic [HOLD_W-1:0] hold;
		logic start_d;
		logic sw_s1;
		logic sw_s2;
		logic sw_d;
		logic fault_d;
		logic done_d;
		logic exec_d;
		logic pend;
		logic card_ld;
		logic ovr_o;
		logic [4:0] leds;
		logic en;
		logic [2:0] ist;
		logic [2:0] imask;
		logic irq;
		logic [31:0] rdata;
	} sli_core_t;

	sli_core_t r;
	sli_core_t n;
	logic fast_ph;
	logic slow_ph;
	logic [2:0] ev;
	logic [2:0] clr;

	// ------------------------------------------------------------
	// Blink prescalers
	// ------------------------------------------------------------
	sli_blink #(.HALF(FAST_HALF)) u_fast (
		.core_clk(core_clk),
		.rst(rst),
		.phase(fast_ph)
	);

	sli_blink #(.HALF(SLOW_HALF)) u_slow (
		.core_clk(core_clk),
		.rst(rst),
		.phase(slow_ph)
	);

	// Indicator pattern {run, stop, fault, force, card} for a mode
	function automatic logic [4:0] pattern(sli_mode_t m, logic f,
		logic s, logic fa, logic fo, logic ca);
		case (m)
			M_FW_LOAD: pattern = {1'b1, f, 3'b111};
			M_INIT1: pattern = 5'h1f;
			M_INIT2: pattern = 5'h1e;
			M_INIT3: pattern = 5'h1c;
			M_INIT4: pattern = 5'h0c;
			M_STOP: pattern = {2'b01, fa, fo, ca};
			M_STARTUP: pattern = {s, 1'b1, fa, fo, ca};
			M_RUN: pattern = {2'b10, fa, fo, ca};
			M_CFG_LOAD: pattern = {1'b0, f, fa, fo, ca};
			M_OVR_REQ: pattern = {1'b0, s, fa, fo, ca};
			M_OVR_EXEC: pattern = {1'b0, f, fa, fo, ca};
			M_FACT_EXEC: pattern = 5'h19;
			M_FACT_DONE: pattern = 5'h0f;
			default: pattern = 5'h00;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		n = r;
		// Switch pin synchroniser
		n.sw_s1 = memory_reset_position;
		n.sw_s2 = r.sw_s1;
		n.sw_d = r.sw_s2;
		n.fault_d = sys_fault;
		n.done_d = fact_done;
		n.exec_d = ovr_exec;
		n.start_d = startup_busy;
		n.ovr_o = r.sw_s2;
		n.card_ld = 1'b0;

		// Boot-up begins with firmware load or an init phase
		if (fw_loading || init_phase != 3'h0)
			n.booted = 1'b1;

		// Start-up display lasts at least the minimum time
		if (startup_busy && !r.start_d)
			n.hold = HOLD_W'(MIN_START);
		else if (r.hold != '0)
			n.hold = r.hold - 1'b1;

		// Memory-reset position: reset, then card load
		if (r.sw_s2 && !r.sw_d)
			n.pend = 1'b1;
		else if (r.exec_d && !ovr_exec && r.pend)
		begin
			n.pend = 1'b0;
			n.card_ld = project_on_card;
		end

		// Display mode by priority
		if (!n.booted)
			n.mode = M_OFF;
		else if (fact_exec)
			n.mode = M_FACT_EXEC;
		else if (fact_done)
			n.mode = M_FACT_DONE;
		else if (fw_loading)
			n.mode = M_FW_LOAD;
		else if (init_phase == 3'h1)
			n.mode = M_INIT1;
		else if (init_phase == 3'h2)
			n.mode = M_INIT2;
		else if (init_phase == 3'h3)
			n.mode = M_INIT3;
		else if (init_phase == 3'h4)
			n.mode = M_INIT4;
		else if (ovr_exec)
			n.mode = M_OVR_EXEC;
		else if (ovr_req || r.sw_s2)
			n.mode = M_OVR_REQ;
		else if (cfg_loading)
			n.mode = M_CFG_LOAD;
		else if (startup_busy || r.hold != '0)
			n.mode = M_STARTUP;
		else if (run_state)
			n.mode = M_RUN;
		else
			n.mode = M_STOP;

		// Lamps; disabled output shows all off
		n.leds = r.en ? pattern(n.mode, fast_ph, slow_ph, sys_fault,
			vars_forced, card_access) : 5'h00;

		// Events and write-one-to-clear; a new event wins
		ev = 3'h0;
		ev[INT_FAULT] = sys_fault && !r.fault_d;
		ev[INT_FDONE] = fact_done && !r.done_d;
		ev[INT_MEMRST] = r.sw_s2 && !r.sw_d;
		clr = (wr && addr == REG_INT_STAT) ? wdata[2:0] : 3'h0;
		n.ist = (r.ist & ~clr) | ev;
		if (wr && addr == REG_INT_MASK)
			n.imask = wdata[2:0];
		if (wr && addr == REG_CTRL)
			n.en = wdata[CTRL_EN_BIT];
		n.irq = (n.ist & n.imask) != 3'h0;

		// Read data only in the cycle after the strobe
		n.rdata = 32'h0;
		if (rd)
		begin
			case (addr)
				REG_CTRL: n.rdata = {31'h0, r.en};
				REG_STATUS: n.rdata = {27'h0, r.booted, r.mode};
				REG_INT_STAT: n.rdata = {29'h0, r.ist};
				REG_INT_MASK: n.rdata = {29'h0, r.imask};
				default: n.rdata = 32'h0;
			endcase
		end
	end

	// State register
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			r <= '0;
			r.mode <= M_OFF;
			r.en <= CTRL_EN_RST;
			r.imask <= INT_MASK_RST;
		end
		else
			r <= n;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign run_indicator = r.leds[4];
	assign stop_indicator = r.leds[3];
	assign fault_indicator = r.leds[2];
	assign force_indicator = r.leds[1];
	assign card_indicator = r.leds[0];
	assign ovr_reset_req = r.ovr_o;
	assign card_load_req = r.card_ld;
	assign rdata = r.rdata;
	assign irq = r.irq;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	logic no_hi;
	assign no_hi = !fact_exec && !fact_done && !fw_loading
		&& init_phase == 3'h0 && !ovr_exec && !ovr_req
		&& !r.sw_s2 && !cfg_loading;

	sequence s_sw_press;
		!r.sw_s2 ##1 r.sw_s2;
	endsequence

	sequence s_exec_end;
		r.pend && ovr_exec ##1 !ovr_exec;
	endsequence

	a_fw_fast_blink: assert property (
		r.booted && r.en && fw_loading && !fact_exec && !fact_done
		|=> stop_indicator == $past(fast_ph) && run_indicator)
		else $error("stop lamp not fast blinking in firmware load");

	a_init_phase_four: assert property (
		r.en && r.mode == M_INIT4 |-> !run_indicator
		&& stop_indicator && fault_indicator && !card_indicator)
		else $error("init phase four pattern wrong");

	a_stop_lamps: assert property (
		r.en && r.mode == M_STOP |-> stop_indicator && !run_indicator)
		else $error("stop state lamps wrong");

	a_start_hold: assert property (
		r.booted && no_hi && r.hold != '0 |=> r.mode == M_STARTUP)
		else $error("start-up display ended early");

	a_run_lamps: assert property (
		r.en && r.booted && no_hi && run_state && !startup_busy
		&& r.hold == '0 && !sys_fault |=> run_indicator
		&& !stop_indicator && !fault_indicator)
		else $error("run state lamps wrong");

	a_fault_follow: assert property (
		r.en && r.booted && no_hi |=> fault_indicator == $past(sys_fault))
		else $error("fault lamp does not follow fault");

	a_force_follow: assert property (
		r.en && r.booted && no_hi |=> force_indicator == $past(vars_forced))
		else $error("force lamp does not follow forcing");

	a_card_follow: assert property (
		r.en && r.booted && no_hi |=> card_indicator == $past(card_access))
		else $error("card lamp does not follow access");

	a_ovr_slow_blink: assert property (
		r.en && r.mode == M_OVR_REQ |-> !run_indicator
		&& stop_indicator == $past(slow_ph))
		else $error("overall reset request blink wrong");

	a_fact_lamps: assert property (
		r.en && r.mode == M_FACT_EXEC |-> r.leds == 5'h19)
		else $error("factory reset lamps wrong");

	a_memrst_request: assert property (
		s_sw_press |=> ovr_reset_req && r.ist[INT_MEMRST] && (r.mode ==
		M_OVR_REQ || $past(!r.booted || fact_exec || fact_done
		|| fw_loading || init_phase != 3'h0 || ovr_exec)))
		else $error("memory reset request not raised");

	a_card_load: assert property (
		s_exec_end |=> card_load_req == $past(project_on_card, 1))
		else $error("card load request wrong after reset");

	a_lamps_off_reset: assert property (
		!r.booted |-> r.leds == 5'h00)
		else $error("lamps lit before boot-up");
endmodule

// File: bench/sli_ctl_model.sv
// Behavioural model of the operating state controller
module sli_ctl_model
	import sli_pkg::*;
(
	// Clock and requested state
	input wire logic core_clk,
	input wire sli_mode_t sel,
	input wire logic [2:0] aux,
	// Controller levels
	output logic fw_loading,
	output logic [2:0] init_phase,
	output logic startup_busy,
	output logic run_state,
	output logic sys_fault,
	output logic vars_forced,
	output logic card_access,
	output logic cfg_loading,
	output logic ovr_req,
	output logic ovr_exec,
	output logic fact_exec,
	output logic fact_done
);
	timeunit 1ns;
	timeprecision 1ps;
	sli_mode_t s = M_OFF;
	logic [2:0] a = 3'h0;
	// Take the request at each rising edge
	always @(posedge core_clk)
	begin
		s <= sel;
		a <= aux;
	end
	// One level per state, side flags straight through
	assign fw_loading = s == M_FW_LOAD;
	assign init_phase = (s >= M_INIT1 && s <= M_INIT4) ? 3'(s - 1) : 3'h0;
	assign startup_busy = s == M_STARTUP;
	assign run_state = s == M_RUN;
	assign {sys_fault, vars_forced, card_access} = a;
	assign cfg_loading = s == M_CFG_LOAD;
	assign ovr_req = s == M_OVR_REQ;
	assign ovr_exec = s == M_OVR_EXEC;
	assign fact_exec = s == M_FACT_EXEC;
	assign fact_done = s == M_FACT_DONE;
endmodule

// File: bench/sli_top_tb.sv
// Self-checking testbench of the status indicator controller
module sli_top_tb
	import sli_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [1:0] k; logic [31:0] m, v;} sli_note_t;
	typedef struct
	{sli_mode_t md; logic [4:0] m, v; logic fol; logic [15:0] tg;} sli_row_t;
	logic core_clk = 0, rst = 1, wr = 0, rd = 0, look = 0;
	logic memory_reset_position = 0, project_on_card = 0;
	logic [3:0] addr = 0;
	logic [31:0] wdata = 0, rdata, seed = 32'h25ac, v;
	sli_mode_t sel = M_OFF;
	logic [2:0] aux = 0, init_phase;
	logic fw_loading, startup_busy, run_state, sys_fault, vars_forced;
	logic card_access, cfg_loading, ovr_req, ovr_exec, fact_exec, fact_done;
	logic ovr_reset_req, card_load_req, irq, run_indicator, stop_indicator;
	logic fault_indicator, force_indicator, card_indicator;
	logic [7:0] rt = 0, st = 0, np = 0;
	logic [15:0] bt = 0;
	int failures = 0, compares = 0;
	sli_note_t q[$];
	string nm[4] = '{"rdata", "lamps", "toggles", "requests"};
	// Mode, mask, pattern {run,stop,fault,force,card}, follow flags, toggles
	sli_row_t tbl[13] = '{
		'{M_OFF, 5'h1f, 5'h00, 1'b0, 16'h0},
		'{M_FW_LOAD, 5'h17, 5'h17, 1'b0, 16'ha},
		'{M_INIT1, 5'h1f, 5'h1f, 1'b0, 16'h0},
		'{M_INIT2, 5'h1f, 5'h1e, 1'b0, 16'h0},
		'{M_INIT3, 5'h1f, 5'h1c, 1'b0, 16'h0},
		'{M_INIT4, 5'h1f, 5'h0c, 1'b0, 16'h0},
		'{M_STOP, 5'h1f, 5'h08, 1'b1, 16'h0},
		'{M_RUN, 5'h1f, 5'h10, 1'b1, 16'h0},
		'{M_CFG_LOAD, 5'h17, 5'h00, 1'b1, 16'ha},
		'{M_OVR_REQ, 5'h17, 5'h00, 1'b1, 16'h4},
		'{M_OVR_EXEC, 5'h17, 5'h00, 1'b1, 16'ha},
		'{M_FACT_EXEC, 5'h1f, 5'h19, 1'b0, 16'h0},
		'{M_FACT_DONE, 5'h1f, 5'h0f, 1'b0, 16'h0}
	};

	sli_ctl_model ctl_u (.core_clk, .sel, .aux, .fw_loading, .init_phase,
		.startup_busy, .run_state, .sys_fault, .vars_forced, .card_access,
		.cfg_loading, .ovr_req, .ovr_exec, .fact_exec, .fact_done);
	sli_top #(.FAST_HALF(4), .SLOW_HALF(10), .MIN_START(50)) dut_u (
		.core_clk, .rst, .fw_loading, .init_phase, .startup_busy,
		.run_state, .sys_fault, .vars_forced, .card_access, .cfg_loading,
		.ovr_req, .ovr_exec, .fact_exec, .fact_done, .project_on_card,
		.memory_reset_position, .ovr_reset_req, .card_load_req,
		.run_indicator, .stop_indicator, .fault_indicator,
		.force_indicator, .card_indicator, .addr, .wdata, .wr, .rd,
		.rdata, .irq);

	// Clock, lamp toggle and request pulse counters
	initial forever #5 core_clk = ~core_clk;
	always @(run_indicator) rt <= rt + 8'h1;
	always @(stop_indicator) st <= st + 8'h1;
	always @(posedge card_load_req) np <= np + 8'h1;

	function automatic logic [31:0] lfsr();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	task automatic tick(int n = 1);
		repeat (n) @(posedge core_clk);
	endtask
	// Note an expectation; the monitor compares it at the next falling edge
	task automatic note(logic [1:0] k, logic [31:0] m, logic [31:0] e);
		q.push_back('{k, m, e});
		look <= 1'b1;
		tick();
		look <= 1'b0;
		tick();
	endtask
	task automatic wreg(logic [3:0] a, logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		tick();
		wr <= 1'b0;
		tick();
	endtask
	task automatic rreg(logic [3:0] a, logic [31:0] e);
		addr <= a;
		rd <= 1'b1;
		tick();
		rd <= 1'b0;
		note(2'd0, 32'hffffffff, e);
	endtask
	task automatic give_verdict();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Monitor: oldest note against what the outputs show
	always @(negedge core_clk)
		if (look === 1'b1)
		begin
			sli_note_t n;
			logic [31:0] s;
			n = q.pop_front();
			s = n.k == 0 ? rdata : n.k == 2 ? {16'h0, rt - bt[15:8], st - bt[7:0]}
				: n.k == 1 ? {27'h0, run_indicator, stop_indicator,
				fault_indicator, force_indicator, card_indicator}
				: {24'h0, ovr_reset_req, irq, np[5:0]};
			compares++;
			if ((s & n.m) !== (n.v & n.m))
			begin
				failures++;
				$display("[ERR] %s expected %h seen %h", nm[n.k], n.v & n.m, s & n.m);
			end
		end

	// Watchdog against a hang
	initial
	begin
		#50000;
		failures++;
		give_verdict();
	end

	// Main sequence
	initial
	begin
		tick(2);
		rst <= 1'b0;
		foreach (tbl[i])
		begin
			sel <= tbl[i].md;
			aux <= 3'(lfsr());
			tick(4);
			v = tbl[i].fol ? {27'h0, tbl[i].v[4:3], aux} : 32'(tbl[i].v);
			note(2'd1, 32'(tbl[i].m), v);
			bt = {rt, st};
			// Window of exactly 40 edges, this edge included
			tick(39);
			note(2'd2, 32'hffff, 32'(tbl[i].tg));
		end
		sel <= M_RUN;
		aux <= 3'h0;
		tick(3);
		rreg(REG_CTRL, 32'h1);
		rreg(REG_STATUS, 32'h18);
		rreg(4'h2, 32'h0);
		rreg(REG_INT_MASK, 32'h0);
		wreg(REG_INT_STAT, 32'h7);
		rreg(REG_INT_STAT, 32'h0);
		wreg(REG_INT_MASK, 32'h1);
		aux <= 3'h4;
		tick(3);
		note(2'd3, 32'h40, 32'h40);
		rreg(REG_INT_STAT, 32'h1);
		wreg(REG_INT_STAT, 32'h1);
		note(2'd3, 32'h40, 32'h0);
		wreg(REG_INT_MASK, 32'h0);
		aux <= 3'h0;
		tick(2);
		aux <= 3'h4;
		tick(3);
		note(2'd3, 32'h40, 32'h0);
		rreg(REG_INT_STAT, 32'h1);
		// Short start-up still blinks run for the minimum time
		sel <= M_STARTUP;
		tick(2);
		sel <= M_STOP;
		tick(3);
		bt = {rt, st};
		tick(39);
		note(2'd2, 32'hffff, 32'h0400);
		tick(20);
		note(2'd1, 32'h18, 32'h08);
		// Memory-reset switch, then reset run with a project on the card
		memory_reset_position <= 1'b1;
		project_on_card <= 1'b1;
		tick(5);
		note(2'd3, 32'h80, 32'h80);
		rreg(REG_INT_STAT, 32'h5);
		sel <= M_OVR_EXEC;
		tick(3);
		memory_reset_position <= 1'b0;
		sel <= M_STOP;
		tick(4);
		note(2'd3, 32'hff, 32'h01);
		wreg(REG_CTRL, 32'h0);
		tick(2);
		note(2'd1, 32'h1f, 32'h0);
		give_verdict();
	end
endmodule
